// ==== logic/dec_ops_pkg.sv ====
/*
  Constants and carrier types for the decrement, divide, loop, interrupt
  enable and threaded-code execution unit of an 8-bit core.
  Assumes the core fetches opcodes and operands and owns memory timing.
*/
package dec_ops_pkg;
  localparam logic [7:0] OP_DEC_R = 8'h00;
  localparam logic [7:0] OP_DEC_IR = 8'h01;
  localparam logic [7:0] OP_WORD_COUNT_DOWN_RR = 8'h80;
  localparam logic [7:0] OP_WORD_COUNT_DOWN_IR = 8'h81;
  localparam logic [7:0] OP_IRQ_OFF = 8'h8F;
  localparam logic [7:0] OP_IRQ_ON = 8'h9F;
  localparam logic [7:0] OP_DIV_R = 8'h94;
  localparam logic [7:0] OP_DIV_IR = 8'h95;
  localparam logic [7:0] OP_DIV_IM = 8'h96;
  localparam logic [3:0] OP_LOOP_LO = 4'hA;
  // Threaded-code opcodes are not fixed here; arbitrary defaults
  localparam logic [7:0] OP_ENTER = 8'h1F;
  localparam logic [7:0] OP_EXIT = 8'h2F;
  localparam logic [4:0] CYC_BYTE = 5'd4;
  localparam logic [4:0] CYC_WORD = 5'd8;
  localparam logic [4:0] CYC_DIV = 5'd26;
  localparam logic [4:0] CYC_DIV0 = 5'd10;
  localparam logic [4:0] CYC_THREAD = 5'd16;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int SYS_IRQ_BIT = 0;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [15:0] dst_word;
    logic [7:0] src_byte;
    logic [7:0] flags;
  } instr_s;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] ip;
    logic [15:0] sp;
  } ptrs_s;
endpackage

// ==== logic/dec_ops_unit.sv ====
/*
  Execution unit for byte/word decrement, global interrupt off/on,
  unsigned divide, loop-count branch and threaded enter/exit.
  Assumes the core presents decoded operands with a start pulse, supplies
  pointers, and performs register and memory reads (single-cycle answer).
*/
// Behaviour
// - Byte decrement, opcodes 00/01, two bytes, four cycles.
// - Decrements update zero, sign, overflow; carry, D, H kept.
// - Word decrement on even pair, opcodes 80/81, eight cycles.
// - Opcode 8F clears system mode bit 0, four cycles, flags kept.
// - Pending bits still set while disabled; no service until enabled.
// - Opcode 9F sets system mode bit 0, four cycles.
// - Pending highest-priority interrupt served once enable executes.
// - Divide 16 by 8: quotient to low byte, remainder to high.
// - Divide 10 cycles if divisor zero else 26; opcodes 94/95/96.
// - Overflow when quotient wide or divisor zero; carry for 9-bit quotient.
// - Zero when divisor or quotient zero; sign from quotient MSB.
// - Loop decrements register, branches by signed displacement if nonzero.
// - Loop opcode rA, register in upper nibble, eight cycles always.
// - Enter pushes IP, IP gets PC, PC from word at IP, IP+2.
// - Exit pops IP, PC from word at IP, IP+2.
// - Interrupt, loop, enter and exit leave flags unchanged.
module dec_ops_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Instruction issue
  input wire logic start,
  input wire dec_ops_pkg::instr_s instr,
  input wire dec_ops_pkg::ptrs_s ptrs_in,
  // Program memory and stack byte read data
  input wire logic [7:0] mem_rdata,
  // Interrupt requests seen by the core
  input wire logic irq_pending,
  // Results
  output logic busy,
  output logic done,
  output logic [15:0] result,
  output logic result_we,
  output logic [7:0] flags_out,
  output dec_ops_pkg::ptrs_s ptrs_out,
  output logic ptrs_we,
  // Memory requests
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic prog_space,
  output logic [15:0] stack_wdata,
  output logic stack_we,
  // System mode and service request
  output logic [7:0] system_mode_reg,
  output logic irq_service
);
  import dec_ops_pkg::*;

  typedef enum {IDLE, WAIT, PUSH, RD_HI, RD_LO, POP_HI, POP_LO} state_e;

  state_e state;
  logic [4:0] cycles;
  logic [15:0] quot;
  logic [7:0] rem;
  logic [7:0] hi_byte;
  logic thread_exit;
  logic write_back;
  logic [15:0] next_result;
  logic [7:0] next_flags;
  logic [4:0] next_cycles;
  logic next_we;

  function automatic logic is_loop(input logic [7:0] op);
    return op[3:0] == OP_LOOP_LO;
  endfunction

  function automatic logic is_div(input logic [7:0] op);
    return op == OP_DIV_R || op == OP_DIV_IR || op == OP_DIV_IM;
  endfunction

  // Quotient kept wide so overflow range can be judged
  always_comb begin
    if (instr.src_byte != 8'h00) begin
      quot = instr.dst_word / {8'h00, instr.src_byte};
      rem = 8'((instr.dst_word % {8'h00, instr.src_byte}));
    end else begin
      quot = 16'h0000;
      rem = 8'h00;
    end
  end

  always_comb begin
    next_result = 16'h0000;
    next_flags = instr.flags;
    next_cycles = CYC_BYTE;
    next_we = 1'b0;
    case (instr.opcode)
      OP_DEC_R, OP_DEC_IR: begin
        next_result = {8'h00, instr.op_a - 8'h01};
        next_we = 1'b1;
        next_flags[FLAG_Z] = next_result[7:0] == 8'h00;
        next_flags[FLAG_S] = next_result[7];
        next_flags[FLAG_V] = instr.op_a == 8'h80;
      end
      OP_WORD_COUNT_DOWN_RR, OP_WORD_COUNT_DOWN_IR: begin
        next_result = instr.dst_word - 16'h0001;
        next_cycles = CYC_WORD;
        next_we = 1'b1;
        next_flags[FLAG_Z] = next_result == 16'h0000;
        next_flags[FLAG_S] = next_result[15];
        next_flags[FLAG_V] = instr.dst_word == 16'h8000;
      end
      OP_DIV_R, OP_DIV_IR, OP_DIV_IM: begin
        next_result = {rem, quot[7:0]};
        next_we = 1'b1;
        next_cycles = (instr.src_byte == 8'h00) ? CYC_DIV0 : CYC_DIV;
        next_flags[FLAG_V] = instr.src_byte == 8'h00 || quot[15:8] != 8'h00;
        next_flags[FLAG_C] = next_flags[FLAG_V] && quot[15:8] == 8'h01;
        next_flags[FLAG_Z] = instr.src_byte == 8'h00 || quot == 16'h0000;
        next_flags[FLAG_S] = quot[7];
      end
      default: begin
        if (is_loop(instr.opcode)) begin
          next_result = {8'h00, instr.op_a - 8'h01};
          next_cycles = CYC_WORD;
          next_we = 1'b1;
        end
      end
    endcase
  end

  // Sequencing and pointer updates
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= IDLE;
      cycles <= 5'd0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 16'h0000;
      result_we <= 1'b0;
      flags_out <= 8'h00;
      ptrs_out <= '0;
      ptrs_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      prog_space <= 1'b0;
      stack_wdata <= 16'h0000;
      stack_we <= 1'b0;
      hi_byte <= 8'h00;
      thread_exit <= 1'b0;
      write_back <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      result_we <= 1'b0;
      ptrs_we <= 1'b0;
      stack_we <= 1'b0;
      mem_rd <= 1'b0;
      case (state)
        IDLE: begin
          if (start) begin
            busy <= 1'b1;
            flags_out <= next_flags;
            result <= next_result;
            write_back <= next_we;
            ptrs_out <= ptrs_in;
            cycles <= next_cycles - 5'd1;
            state <= WAIT;
            if (is_loop(instr.opcode) && next_result[7:0] != 8'h00) begin
              ptrs_out.pc <= ptrs_in.pc + {{8{instr.op_b[7]}}, instr.op_b};
            end
            if (instr.opcode == OP_ENTER) begin
              ptrs_out.sp <= ptrs_in.sp - WORD_STEP;
              stack_wdata <= ptrs_in.ip;
              // Store strobe stands with the stack address
              stack_we <= 1'b1;
              mem_addr <= ptrs_in.sp - WORD_STEP;
              ptrs_out.ip <= ptrs_in.pc;
              thread_exit <= 1'b0;
              state <= PUSH;
            end else if (instr.opcode == OP_EXIT) begin
              mem_addr <= ptrs_in.sp;
              mem_rd <= 1'b1;
              prog_space <= 1'b0;
              thread_exit <= 1'b1;
              cycles <= CYC_THREAD - 5'd1;
              state <= POP_HI;
            end
          end
        end
        PUSH: begin
          cycles <= CYC_THREAD - 5'd1;
          mem_addr <= ptrs_out.ip;
          mem_rd <= 1'b1;
          prog_space <= 1'b1;
          state <= RD_HI;
        end
        POP_HI: begin
          hi_byte <= mem_rdata;
          mem_addr <= mem_addr + 16'h0001;
          mem_rd <= 1'b1;
          state <= POP_LO;
        end
        POP_LO: begin
          ptrs_out.ip <= {hi_byte, mem_rdata};
          ptrs_out.sp <= ptrs_out.sp + WORD_STEP;
          mem_addr <= {hi_byte, mem_rdata};
          mem_rd <= 1'b1;
          prog_space <= 1'b1;
          state <= RD_HI;
        end
        RD_HI: begin
          hi_byte <= mem_rdata;
          mem_addr <= mem_addr + 16'h0001;
          mem_rd <= 1'b1;
          state <= RD_LO;
        end
        RD_LO: begin
          ptrs_out.pc <= {hi_byte, mem_rdata};
          ptrs_out.ip <= ptrs_out.ip + WORD_STEP;
          prog_space <= 1'b0;
          state <= WAIT;
        end
        WAIT: begin
          if (cycles <= 5'd1) begin
            busy <= 1'b0;
            done <= 1'b1;
            result_we <= write_back && !thread_exit;
            ptrs_we <= 1'b1;
            thread_exit <= 1'b0;
            state <= IDLE;
          end else begin
            cycles <= cycles - 5'd1;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      system_mode_reg <= 8'h00;
    end else if (clk_en && start && state == IDLE) begin
      if (instr.opcode == OP_IRQ_OFF) begin
        system_mode_reg[SYS_IRQ_BIT] <= 1'b0;
      end else if (instr.opcode == OP_IRQ_ON) begin
        system_mode_reg[SYS_IRQ_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_service <= 1'b0;
    end else if (clk_en) begin
      irq_service <= irq_pending && system_mode_reg[SYS_IRQ_BIT] && state == IDLE;
    end
  end

  // Two-byte reads, next address one cycle later
  sequence prog_word_s;
    mem_rd && prog_space ##1 mem_rd && prog_space && mem_addr == $past(mem_addr) + 16'h0001;
  endsequence

  sequence stack_word_s;
    mem_rd && !prog_space ##1 mem_rd && !prog_space && mem_addr == $past(mem_addr) + 16'h0001;
  endsequence

  a_irq_gated: assert property (@(posedge ref_clk) disable iff (reset)
    irq_service |-> $past(system_mode_reg[SYS_IRQ_BIT]))
    else $error("Interrupt serviced while disabled");

  a_div_zero_len: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && is_div(instr.opcode) && instr.src_byte == 8'h00
    |=> (busy && !done) [*8] ##1 busy ##1 done)
    else $error("Divide by zero timing wrong");

  a_div_full_len: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && is_div(instr.opcode) && instr.src_byte != 8'h00
    |-> ##26 done)
    else $error("Divide timing wrong");

  a_dec_len: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && instr.opcode == OP_DEC_R |=> busy [*3] ##1 done)
    else $error("Byte decrement timing wrong");

  a_word_dec_len: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && (instr.opcode == OP_WORD_COUNT_DOWN_RR || instr.opcode == OP_WORD_COUNT_DOWN_IR)
    |-> ##8 done)
    else $error("Word decrement timing wrong");

  a_irq_off_clears: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && instr.opcode == OP_IRQ_OFF
    |=> !system_mode_reg[SYS_IRQ_BIT])
    else $error("Interrupt allow bit not cleared");

  a_irq_on_sets: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && instr.opcode == OP_IRQ_ON
    |=> system_mode_reg[SYS_IRQ_BIT])
    else $error("Interrupt allow bit not set");

  a_flags_kept: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && (instr.opcode == OP_IRQ_OFF || instr.opcode == OP_IRQ_ON
    || instr.opcode == OP_ENTER || instr.opcode == OP_EXIT || is_loop(instr.opcode))
    |=> flags_out == $past(instr.flags))
    else $error("Flags changed by flag-free operation");

  a_enter_steps: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && instr.opcode == OP_ENTER
    |=> stack_we && mem_addr == $past(ptrs_in.sp) - WORD_STEP
    && stack_wdata == $past(ptrs_in.ip) ##1 prog_word_s)
    else $error("Enter step order wrong");

  a_exit_steps: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && start && state == IDLE && instr.opcode == OP_EXIT
    |=> stack_word_s ##1 prog_word_s)
    else $error("Exit step order wrong");
endmodule // dec_ops_unit

// ==== tb/testbench.sv ====
/*
  Randomised self-checking bench for dec_ops_unit.
  Assumes the unit answers with one done pulse and wants read data in the
  same cycle as its address.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dec_ops_pkg::*;
  typedef struct packed {
    logic [4:0] c;
    logic [7:0] f;
    logic [7:0] m;
    logic [15:0] r;
    logic [15:0] rm;
    logic w;
  } exp_s;
  logic ref_clk, reset, start, irq_pending, busy, done, result_we, ptrs_we;
  logic mem_rd, prog_space, stack_we, irq_service;
  logic [7:0] mem_rdata, flags_out, system_mode_reg;
  logic [15:0] result, mem_addr, stack_wdata, pushed, pushed_at;
  instr_s instr;
  ptrs_s ptrs_in, ptrs_out;
  int error_cnt = 0;
  int comparisons = 0;
  int n;

  dec_ops_unit dut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .start(start),
    .instr(instr), .ptrs_in(ptrs_in), .mem_rdata(mem_rdata), .irq_pending(irq_pending),
    .busy(busy), .done(done), .result(result), .result_we(result_we),
    .flags_out(flags_out), .ptrs_out(ptrs_out), .ptrs_we(ptrs_we), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .prog_space(prog_space), .stack_wdata(stack_wdata),
    .stack_we(stack_we), .system_mode_reg(system_mode_reg), .irq_service(irq_service));

  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Memory content follows space and address
  function automatic logic [7:0] mb(logic s, logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ (s ? 8'h5A : 8'hA5);
  endfunction
  function automatic logic [15:0] mw(logic s, logic [15:0] a);
    return {mb(s, a), mb(s, a + 16'h0001)};
  endfunction
  assign mem_rdata = mem_rd ? mb(prog_space, mem_addr) : 8'h00;
  always @(posedge ref_clk) begin
    if (stack_we === 1'b1) begin
      pushed <= stack_wdata;
      pushed_at <= mem_addr;
    end
  end

  function automatic exp_s calc(instr_s i);
    exp_s e;
    logic [15:0] q;
    e = '{c: CYC_BYTE, f: i.flags, m: 8'hFF, r: {8'h00, i.dst_word[7:0] - 8'h01},
      rm: 16'h00FF, w: 1'b1};
    case (i.opcode)
      OP_DEC_R, OP_DEC_IR: e.f[6:4] = {e.r[7:0] == 8'h00, e.r[7], i.dst_word[7:0] == 8'h80};
      OP_WORD_COUNT_DOWN_RR, OP_WORD_COUNT_DOWN_IR: begin
        e.c = CYC_WORD;
        e.r = i.dst_word - 16'h0001;
        e.rm = 16'hFFFF;
        e.f[6:4] = {e.r == 16'h0000, e.r[15], i.dst_word == 16'h8000};
      end
      OP_DIV_R, OP_DIV_IR, OP_DIV_IM: begin
        e.c = CYC_DIV0;
        e.f[7:4] = 4'b0101;
        e.m = 8'hD0;
        e.rm = 16'h0000;
        if (i.src_byte != 8'h00) begin
          q = i.dst_word / i.src_byte;
          e.c = CYC_DIV;
          e.f[7:4] = {q > 255 && q < 512, q == 0, q[7], q > 255};
          if (q < 256) begin
            e.m = 8'hFF;
            e.rm = 16'hFFFF;
            e.r = {8'(i.dst_word % i.src_byte), q[7:0]};
          end
        end
      end
      OP_IRQ_OFF, OP_IRQ_ON: begin
        e.rm = 16'h0000;
        e.w = 1'b0;
      end
      OP_ENTER, OP_EXIT: begin
        e.c = 0;
        e.rm = 16'h0000;
        e.w = 1'b0;
      end
      default: begin
        e.c = CYC_WORD;
        e.r = {8'h00, i.op_a - 8'h01};
      end
    endcase
    return e;
  endfunction

  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic go(input instr_s i, input ptrs_s p);
    exp_s e;
    e = calc(i);
    @(posedge ref_clk);
    instr <= i;
    ptrs_in <= p;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    // Taking edge counts as the first cycle
    n = 1;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (done !== 1'b1 && n < 60);
    chk(n < 60 && (e.c == 0 || n == int'(e.c)), "cycle count");
    chk((flags_out & e.m) === (e.f & e.m), "flags");
    chk((result & e.rm) === (e.r & e.rm), "result");
    chk(result_we === e.w && ptrs_we === 1'b1 && busy === 1'b0, "strobes");
  endtask

  initial begin
    instr_s i;
    ptrs_s p;
    logic [7:0] ops[7] = '{OP_DEC_R, OP_DEC_IR, OP_WORD_COUNT_DOWN_RR, OP_WORD_COUNT_DOWN_IR, OP_DIV_R, OP_DIV_IR,
      OP_DIV_IM};
    logic [15:0] cd[5] = '{16'h0000, 16'h0001, 16'h8000, 16'h0080, 16'h01FF};
    logic [7:0] cs[5] = '{8'h00, 8'h01, 8'h01, 8'h05, 8'h01};
    reset = 1;
    start = 0;
    instr = '0;
    ptrs_in = '0;
    irq_pending = 0;
    void'($urandom(92));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    for (int k = 0; k < 140; k++) begin
      i = 56'({$urandom, $urandom});
      p = 48'({$urandom, $urandom});
      i.opcode = ops[k % 7];
      if (k < 35) begin
        i.dst_word = cd[k / 7];
        i.src_byte = cs[k / 7];
      end else begin
        i.src_byte = i.src_byte | 8'h01;
        i.dst_word[15:8] = i.dst_word[15:8] % i.src_byte;
      end
      i.op_a = i.dst_word[7:0];
      go(i, p);
    end
    for (int k = 0; k < 12; k++) begin
      i = 56'({$urandom, $urandom});
      p = 48'({$urandom, $urandom});
      // counter register taken as already in the working bank
      i.opcode = {i.opcode[7:4], OP_LOOP_LO};
      if (k < 3) i.op_a = 8'(k);
      if (k == 3) i.op_b = 8'h80;
      if (k == 4) i.op_b = 8'h7F;
      go(i, p);
      chk(ptrs_out.pc === (i.op_a == 8'h01 ? p.pc : p.pc + {{8{i.op_b[7]}}, i.op_b}), "loop pc");
    end
    @(posedge ref_clk);
    // pending raised while still globally disabled
    irq_pending <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      i.opcode = (k == 1) ? OP_IRQ_OFF : OP_IRQ_ON;
      go(i, p);
      repeat (3) @(posedge ref_clk);
      #1;
      chk(system_mode_reg[0] === (k != 1) && irq_service === (k != 1), "irq state");
    end
    i.opcode = OP_ENTER;
    go(i, p);
    chk(ptrs_out === ptrs_s'{pc: mw(1'b1, p.pc), ip: p.pc + WORD_STEP, sp: p.sp - WORD_STEP},
      "enter");
    chk(pushed === p.ip && pushed_at === p.sp - WORD_STEP, "pushed ip");
    i.opcode = OP_EXIT;
    go(i, p);
    chk(ptrs_out === ptrs_s'{pc: mw(1'b1, mw(1'b0, p.sp)), ip: mw(1'b0, p.sp) + WORD_STEP,
      sp: p.sp + WORD_STEP}, "exit");
    report_and_stop();
  end

  initial begin
    #500us;
    error_cnt++;
    report_and_stop();
  end
endmodule // testbench
